//--- bench/nsm_conv_model.sv
// behavioural converter bank behind the controller
`timescale 1ns/1ps
module nsm_conv_model
  import nsm_pkg::*;
(
  input wire logic ref_clk, // clock
  input wire logic conv_integ, // integration active
  input wire logic [1:0] pass_idx, // current pass
  output logic [15:0] conv_data [NSM_NUM_CONV] // results
);
  // counts encode pass and converter so a misplaced word shows up
  always_ff @(posedge ref_clk) begin
    for (int k = 0; k < NSM_NUM_CONV; k++) begin
      if (conv_integ) begin
        conv_data[k] <= {4'ha, 2'h0, pass_idx, 4'(k), 4'h3};
      end
    end
  end
endmodule : nsm_conv_model

//--- bench/nsm_ctrl_asserts.sv
// port assertions for the measurement controller
`timescale 1ns/1ps
module nsm_ctrl_chk
  import nsm_pkg::*;
(
  input wire logic ref_clk, // clock
  input wire logic rstn, // reset, active low
  input wire logic rst_pin, // reset pin
  input wire logic bus_wr, // write strobe
  input wire logic bus_rd, // read strobe
  input wire logic bus_ack, // access accepted
  input wire logic conv_az, // zeroing phase
  input wire logic conv_cfg, // config phase
  input wire logic conv_integ, // integration phase
  input wire logic [3:0] conv_gain [NSM_NUM_CONV], // gain codes
  input wire logic [1:0] pass_idx, // current pass
  input wire logic osc_en // oscillator running
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  sequence az_run;
    conv_az[*8] ##1 conv_az[*8];
  endsequence
  sequence cfg_run;
    conv_cfg[*8] ##1 conv_cfg[*8];
  endsequence
  chk_ack_has_cause: assert property (bus_ack |-> $past(bus_wr || bus_rd))
    else $error("ack without strobe");
  chk_pin_blocks_bus: assert property (rst_pin[*6] |=> !bus_ack)
    else $error("ack while reset pin held");
  chk_sleep_quiet: assert property (!osc_en |-> !(conv_az || conv_cfg || conv_integ))
    else $error("phase active with oscillator off");
  chk_phase_excl: assert property ($onehot0({conv_az, conv_cfg, conv_integ}))
    else $error("phases overlap");
  chk_az_then_cfg: assert property ($rose(conv_az) |-> az_run ##1 conv_cfg)
    else $error("zeroing length or successor wrong");
  chk_cfg_then_int: assert property ($rose(conv_cfg) |-> cfg_run ##1 conv_integ)
    else $error("config length or successor wrong");
  chk_pass_step: assert property ($changed(pass_idx) |->
    pass_idx == 2'h0 || pass_idx == $past(pass_idx) + 2'h1)
    else $error("pass index skipped");
  chk_gain_cap: assert property (conv_integ |-> conv_gain[0] <= NSM_GAIN_MAX)
    else $error("gain code above maximum");
endmodule : nsm_ctrl_chk

bind nsm_ctrl nsm_ctrl_chk nsm_ctrl_chk_inst (.ref_clk, .rstn, .rst_pin, .bus_wr, .bus_rd,
  .bus_ack, .conv_az, .conv_cfg, .conv_integ, .conv_gain, .pass_idx, .osc_en);

//--- bench/tb_nsm_ctrl.sv
// self-checking bench for the measurement controller
`timescale 1ns/1ps
module tb_nsm_ctrl;
  import nsm_pkg::*;
  logic ref_clk = 0, rstn = 0, rst_pin = 0, bus_wr = 0, bus_rd = 0, gpio_in = 0;
  logic [7:0] bus_addr = 8'h00, bus_wdata = 8'h00, bus_rdata;
  logic bus_ack, gpio_out, gpio_oe_n, conv_az, conv_cfg, conv_integ, lamp_high, osc_en;
  logic [15:0] conv_data [NSM_NUM_CONV];
  logic [3:0] conv_gain [NSM_NUM_CONV];
  logic [1:0] conv_pd_sel [NSM_NUM_CONV];
  logic [1:0] pass_idx;
  logic [3:0] lamp_en;
  int n_fail = 0, n_tests = 0;
  always #10 ref_clk = ~ref_clk;
  // short init keeps the run brief
  nsm_ctrl #(.INIT_CYCLES(20)) nsm_ctrl_inst (.ref_clk, .rstn, .rst_pin, .bus_wr, .bus_rd,
    .bus_addr, .bus_wdata, .bus_rdata, .bus_ack, .gpio_in, .gpio_out, .gpio_oe_n,
    .conv_data, .conv_az, .conv_cfg, .conv_integ, .conv_gain, .conv_pd_sel, .pass_idx,
    .lamp_en, .lamp_high, .osc_en);
  nsm_conv_model nsm_conv_model_inst (.ref_clk, .conv_integ, .pass_idx, .conv_data);
  task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d,
    output logic [7:0] q, output logic k);
    @(posedge ref_clk);
    bus_wr <= w;
    bus_rd <= !w;
    bus_addr <= a;
    bus_wdata <= d;
    @(posedge ref_clk);
    bus_wr <= 1'b0;
    bus_rd <= 1'b0;
    #1;
    k = bus_ack;
    q = bus_rdata;
  endtask : acc
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    logic k;
    acc(1'b1, a, d, q, k);
    chk("write ack", {7'h0, k}, 8'h01);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    logic k;
    acc(1'b0, a, 8'h00, q, k);
    chk("read ack", {7'h0, k}, 8'h01);
  endtask : rd
  task automatic t_init;
    logic [7:0] q;
    logic k;
    acc(1'b1, NSM_ADDR_ENABLE, 8'h01, q, k);
    chk("init ack", {7'h0, k}, 8'h00);
    repeat (30) @(posedge ref_clk);
    rd(NSM_ADDR_ENABLE, q);
    chk("dropped write", q, 8'h00);
    rd(NSM_ADDR_STATUS, q);
    chk("sleep state", {4'h0, q[3:0]}, {4'h0, NSM_SLEEP});
    chk("osc in sleep", {7'h0, osc_en}, 8'h00);
  endtask : t_init
  task automatic t_regs;
    logic [7:0] q;
    for (int a = 8'h60; a <= 8'h67; a++) begin
      wr(8'(a), 8'(a) ^ 8'h0a);
      rd(8'(a), q);
      chk("reg readback", q, 8'(a) ^ 8'h0a);
    end
    rd(8'h70, q);
    chk("unmapped", q, 8'h00);
  endtask : t_regs
  task automatic t_meas;
    logic [7:0] q;
    logic prev;
    logic [3:0] la;
    int n, len, i;
    wr(NSM_ADDR_ENABLE, 8'h01);
    repeat (3) @(posedge ref_clk);
    chk("osc on", {7'h0, osc_en}, 8'h01);
    wr(NSM_ADDR_GAIN0, 8'h09);
    rd(NSM_ADDR_GAIN0, q);
    chk("gain clamp", q, 8'h08);
    wr(NSM_ADDR_MUX0, 8'h03);
    wr(NSM_ADDR_LAMP, 8'h1f);
    wr(NSM_ADDR_ITIME0, 8'h05);
    wr(8'h62, 8'h00);
    wr(NSM_ADDR_ITIME2, 8'h00);
    wr(NSM_ADDR_WTIME0, 8'h1e);
    wr(8'h65, 8'h00);
    wr(8'h66, 8'h00);
    wr(NSM_ADDR_WTIME3, 8'h00);
    wr(NSM_ADDR_ENABLE, 8'h03);
    n = 0;
    len = 0;
    prev = 0;
    la = 4'h0;
    for (i = 0; i < 2000 && gpio_out !== 1'b1; i++) begin
      @(posedge ref_clk);
      #1;
      if (conv_integ && !prev) n++;
      if (conv_integ) len++;
      if (conv_integ) la = lamp_en;
      prev = conv_integ;
    end
    chk("passes", 8'(n), 8'h04);
    chk("integ length", 8'(len), 8'h18);
    chk("irq drive", {7'h0, gpio_oe_n}, 8'h00);
    chk("gain loaded", {4'h0, conv_gain[0]}, 8'h08);
    chk("mux loaded", {6'h0, conv_pd_sel[0]}, 8'h03);
    chk("lamp current", {7'h0, lamp_high}, 8'h00);
    rd(NSM_ADDR_STATUS, q);
    chk("done flag", {7'h0, q[4]}, 8'h01);
    for (i = 0; i < 300 && conv_integ !== 1'b1; i++) begin
      @(posedge ref_clk);
      #1;
    end
    chk("lamp alternation", {4'h0, la ^ lamp_en}, 8'h0f);
    wr(NSM_ADDR_ENABLE, 8'h01);
    repeat (2) @(posedge ref_clk);
    rd(NSM_ADDR_STATUS, q);
    chk("back to idle", {4'h0, q[3:0]}, {4'h0, NSM_IDLE});
    rd(NSM_ADDR_DATA0 + 8'h02, q);
    chk("result low", q, 8'h13);
    rd(NSM_ADDR_DATA0 + 8'h03, q);
    chk("result high", q, 8'ha0);
  endtask : t_meas
  task automatic t_rst;
    logic [7:0] q;
    logic k;
    @(posedge ref_clk);
    rst_pin <= 1'b1;
    repeat (6) @(posedge ref_clk);
    acc(1'b1, NSM_ADDR_ENABLE, 8'h03, q, k);
    chk("pin reset ack", {7'h0, k}, 8'h00);
    @(posedge ref_clk);
    rst_pin <= 1'b0;
    repeat (30) @(posedge ref_clk);
    rd(NSM_ADDR_STATUS, q);
    chk("pin reset sleep", {4'h0, q[3:0]}, {4'h0, NSM_SLEEP});
  endtask : t_rst
  // cycles from one rise of the integration phase to the next
  task automatic integ_gap(output int g);
    int i;
    g = 0;
    for (i = 0; i < 500 && conv_integ !== 1'b1; i++) begin
      @(posedge ref_clk);
      #1;
    end
    for (i = 0; i < 500 && conv_integ === 1'b1; i++) begin
      @(posedge ref_clk);
      #1;
      g++;
    end
    for (i = 0; i < 500 && conv_integ !== 1'b1; i++) begin
      @(posedge ref_clk);
      #1;
      g++;
    end
  endtask : integ_gap
  task automatic cfg_lamps(output logic [7:0] la);
    for (int i = 0; i < 200 && conv_cfg !== 1'b1; i++) begin
      @(posedge ref_clk);
      #1;
    end
    la = {4'h0, lamp_en};
  endtask : cfg_lamps
  task automatic t_modes;
    logic [7:0] q;
    int g;
    wr(NSM_ADDR_ITIME0, 8'h05);
    wr(NSM_ADDR_WTIME0, 8'h0a);
    wr(NSM_ADDR_LAMP, 8'h0f);
    wr(NSM_ADDR_ENABLE, 8'h1b);
    repeat (8) @(posedge ref_clk);
    rd(NSM_ADDR_STATUS, q);
    chk("trigger wait", {4'h0, q[3:0]}, {4'h0, NSM_TRIG});
    chk("trigger input", {7'h0, gpio_oe_n}, 8'h01);
    @(posedge ref_clk);
    gpio_in <= 1'b1;
    integ_gap(g);
    chk("interpass wait", 8'(g), 8'h41);
    cfg_lamps(q);
    chk("lamps off in config", q, 8'h00);
    wr(NSM_ADDR_ENABLE, 8'h11);
    @(posedge ref_clk);
    gpio_in <= 1'b0;
    wr(NSM_ADDR_LAMP, 8'h2f);
    wr(NSM_ADDR_ENABLE, 8'h0b);
    integ_gap(g);
    chk("gated wait", 8'(g), 8'h36);
    cfg_lamps(q);
    chk("lamps on in config", q, 8'h0f);
  endtask : t_modes
  task automatic wrap_up;
    if (n_fail == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : wrap_up
  initial begin
    repeat (4) @(posedge ref_clk);
    rstn <= 1'b1;
    t_init;
    t_regs;
    t_meas;
    t_rst;
    t_modes;
    wrap_up;
  end
  // whole run is under a thousand cycles, so this only trips on a hang
  initial begin
    #100000;
    n_fail++;
    wrap_up;
  end
endmodule : tb_nsm_ctrl

//--- rtl/nsm_ctrl.sv
// measurement sequencer and power-state control for the spectral sensor
// Behaviour
// R1: no bus access accepted while initialising
// R2: host waits and ignores outputs during init
// R3: after init enter sleep, oscillator stopped
// R4: bus serviced in sleep without waking
// R5: power bit set enters idle state
// R6: measurement enable set enters active state
// R7: measurement enable cleared returns to idle
// R8: sixteen 16-bit converters, own gain, integration time
// R9: four passes run automatically per measurement
// R10: 128 result bytes, read after four passes; code exposes only 64 bytes, the words of passes 0-1
// R11: gpio is trigger input or interrupt output
// R12: reset pin is active high
// R13: mux routes photodiodes to sixteen converters
// R14: mux configuration held in internal ram
// R15: gain codes 0 (1x) to 8 (256x)
// R16: each pass starts with offset zeroing
// R17: config phase loads setup and mux values
// R18: integration length from bytes 0x61-0x63
// R19: store phase writes sixteen 16-bit results
// R20: move, wait, then next measurement auto-starts
// R21: optional interpass wait from bytes at 0x64
// R22: four lamp sinks, 50 or 75 mA
// R23: host waits 10 s after 4x75 mA
// R24: lamp alternation toggles lamps per measurement
// R25: lamp wait gate picks cycle variant
`timescale 1ns/1ps
module nsm_ctrl
  import nsm_pkg::*;
#(
  parameter int INIT_CYCLES = NSM_INIT_CYCLES
) (
  input wire logic ref_clk, // system clock, 50 MHz
  input wire logic rstn, // async reset, active low
  input wire logic rst_pin, // reset pin, active high
  input wire logic bus_wr, // register write strobe
  input wire logic bus_rd, // register read strobe
  input wire logic [7:0] bus_addr, // register byte address
  input wire logic [7:0] bus_wdata, // write data
  output logic [7:0] bus_rdata, // read data
  output logic bus_ack, // access accepted
  input wire logic gpio_in, // gpio pin input
  output logic gpio_out, // gpio pin output value
  output logic gpio_oe_n, // gpio output enable, low drives
  input wire logic [15:0] conv_data [NSM_NUM_CONV], // converter results
  output logic conv_az, // offset zeroing active
  output logic conv_cfg, // setup load strobe level
  output logic conv_integ, // integration active
  output logic [3:0] conv_gain [NSM_NUM_CONV], // per-converter gain code
  output logic [1:0] conv_pd_sel [NSM_NUM_CONV], // mux selection per converter
  output logic [1:0] pass_idx, // current pass
  output logic [3:0] lamp_en, // lamp sink enables
  output logic lamp_high, // 1 selects 75 mA, else 50 mA
  output logic osc_en // internal oscillator running
);
  logic rst_sync;
  logic gpio_sync;
  logic rst_n_int;
  nsm_sync #(.W(2)) u_sync (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .din({rst_pin, gpio_in}),
    .dout({rst_sync, gpio_sync})
  );
  assign rst_n_int = !rst_sync; // R12

  nsm_state_t st_q, st_d;
  logic [31:0] cnt_q, cnt_d;
  logic [1:0] pass_q, pass_d;
  logic lamp_phase_q, lamp_phase_d;
  logic done_q, done_d;
  logic gpio_q, gpio_d;
  logic gpio_trig_q;
  logic [7:0] lamp_cfg_q;
  logic [23:0] itime_q;
  logic [31:0] wtime_q;
  logic [7:0] enable_q;
  logic [3:0] gain_q [NSM_NUM_CONV];
  logic [1:0] mux_q [NSM_NUM_CONV];
  logic [15:0] ram_q [NSM_NUM_CONV*NSM_NUM_PASS];
  logic [15:0] ram_hold_q;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic ack_q;
  logic interpass_delay_on;
  logic gate_wait;
  logic trig_mode;
  logic [31:0] itime_cyc;
  logic [4:0] store_idx;
  logic [5:0] ram_idx;

  assign interpass_delay_on = enable_q[NSM_ENABLE_INTERPASS_DELAY_BIT];
  assign gate_wait = lamp_cfg_q[NSM_LAMP_WAIT_GATE_BIT];
  assign trig_mode = enable_q[NSM_ENABLE_GPIO_TRIG_BIT];
  assign itime_cyc = {8'h00, itime_q}; // R18
  assign store_idx = cnt_q[4:0];

  // sequencer next state
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q + 32'h1;
    pass_d = pass_q;
    lamp_phase_d = lamp_phase_q;
    done_d = done_q;
    gpio_d = 1'b0;
    unique case (st_q)
      NSM_INIT: begin
        if (cnt_q >= 32'(INIT_CYCLES - 1)) begin
          st_d = NSM_SLEEP; // R3
          cnt_d = '0;
        end
      end
      NSM_SLEEP: begin
        cnt_d = '0;
        if (enable_q[NSM_ENABLE_POWER_BIT]) st_d = NSM_IDLE; // R5
      end
      NSM_IDLE: begin
        cnt_d = '0;
        pass_d = '0;
        if (!enable_q[NSM_ENABLE_POWER_BIT]) st_d = NSM_SLEEP;
        else if (enable_q[NSM_ENABLE_MEAS_BIT]) begin
          st_d = trig_mode ? NSM_TRIG : NSM_AZ; // R6 R11
          done_d = 1'b0;
        end
      end
      NSM_TRIG: begin
        cnt_d = '0;
        if (gpio_trig_q) st_d = NSM_AZ; // R11
      end
      NSM_AZ: begin
        if (cnt_q >= 32'(NSM_AZ_CYCLES - 1)) begin
          st_d = NSM_CFG; // R16
          cnt_d = '0;
        end
      end
      NSM_CFG: begin
        if (cnt_q >= 32'(NSM_CFG_CYCLES - 1)) begin
          st_d = NSM_INTEG; // R17
          cnt_d = '0;
        end
      end
      NSM_INTEG: begin
        if (cnt_q >= itime_cyc) begin
          st_d = NSM_STORE; // R18
          cnt_d = '0;
        end
      end
      NSM_STORE: begin
        if (cnt_q >= 32'(NSM_STORE_CYCLES - 1)) begin
          cnt_d = '0;
          if (pass_q == 2'(NSM_NUM_PASS - 1)) begin
            st_d = NSM_MOVE; // R9
            done_d = 1'b1; // R10
            gpio_d = 1'b1;
          end else begin
            pass_d = pass_q + 2'h1;
            // gate set: no interpass wait at all, so the next zeroing follows the store directly
            st_d = (interpass_delay_on && !gate_wait) ? NSM_INTERPASS_DELAY : NSM_AZ; // R21 R25
          end
        end
      end
      NSM_INTERPASS_DELAY: begin
        if (cnt_q >= wtime_q) begin
          st_d = NSM_AZ; // R21
          cnt_d = '0;
        end
      end
      NSM_MOVE: begin
        st_d = NSM_INTERMEASURE_DELAY; // R20
        cnt_d = '0;
        pass_d = '0;
        if (lamp_cfg_q[NSM_LAMP_ALT_BIT]) lamp_phase_d = !lamp_phase_q; // R24
      end
      NSM_INTERMEASURE_DELAY: begin
        if (cnt_q >= wtime_q) begin
          cnt_d = '0;
          st_d = trig_mode ? NSM_TRIG : NSM_AZ; // R20
        end
      end
      default: begin
        st_d = NSM_IDLE;
        cnt_d = '0;
      end
    endcase
    // R7: clearing enable aborts back to idle
    if (st_q > NSM_IDLE && !enable_q[NSM_ENABLE_MEAS_BIT]) begin
      st_d = NSM_IDLE; // R7
      cnt_d = '0;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= NSM_INIT;
      cnt_q <= '0;
      pass_q <= '0;
      lamp_phase_q <= 1'b0;
      done_q <= 1'b0;
      gpio_q <= 1'b0;
      gpio_trig_q <= 1'b0;
    end else if (!rst_n_int) begin
      st_q <= NSM_INIT;
      cnt_q <= '0;
      pass_q <= '0;
      lamp_phase_q <= 1'b0;
      done_q <= 1'b0;
      gpio_q <= 1'b0;
      gpio_trig_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      pass_q <= pass_d;
      lamp_phase_q <= lamp_phase_d;
      done_q <= done_d;
      gpio_q <= gpio_d;
      gpio_trig_q <= gpio_sync;
    end
  end

  // register file and result ram
  assign ram_idx = {pass_q, store_idx[3:0]};
  always_comb begin
    rdata_d = NSM_RESET_BYTE;
    if (bus_addr == NSM_ADDR_LAMP) rdata_d = lamp_cfg_q;
    else if (bus_addr >= NSM_ADDR_ITIME0 && bus_addr <= NSM_ADDR_ITIME2)
      rdata_d = itime_q[8*(bus_addr - NSM_ADDR_ITIME0) +: 8];
    else if (bus_addr >= NSM_ADDR_WTIME0 && bus_addr <= NSM_ADDR_WTIME3)
      rdata_d = wtime_q[8*(bus_addr - NSM_ADDR_WTIME0) +: 8];
    else if (bus_addr == NSM_ADDR_ENABLE) rdata_d = enable_q;
    else if (bus_addr == NSM_ADDR_STATUS) rdata_d = {3'h0, done_q, st_q};
    else if (bus_addr >= NSM_ADDR_GAIN0 && bus_addr < NSM_ADDR_GAIN0 + 8'h10)
      rdata_d = {4'h0, gain_q[bus_addr[3:0]]};
    else if (bus_addr >= NSM_ADDR_MUX0 && bus_addr < NSM_ADDR_MUX0 + 8'h10)
      rdata_d = {6'h00, mux_q[bus_addr[3:0]]};
    else if (bus_addr >= NSM_ADDR_DATA0) begin
      // low byte latches the word so the high byte reads consistently
      // the 64-byte window reaches the words of the first two passes only
      if (!bus_addr[0]) rdata_d = ram_q[{1'b0, bus_addr[5:1]}][7:0]; // R10
      else rdata_d = ram_hold_q[15:8];
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      lamp_cfg_q <= '0;
      itime_q <= '0;
      wtime_q <= '0;
      enable_q <= '0;
      rdata_q <= '0;
      ack_q <= 1'b0;
      ram_hold_q <= '0;
      for (int i = 0; i < NSM_NUM_CONV; i++) begin
        gain_q[i] <= '0;
        mux_q[i] <= '0;
      end
      for (int i = 0; i < NSM_NUM_CONV*NSM_NUM_PASS; i++) ram_q[i] <= '0;
    end else if (!rst_n_int) begin
      // pin reset drops the lamp, time and enable registers too, else a kept power bit skips sleep
      lamp_cfg_q <= '0;
      itime_q <= '0;
      wtime_q <= '0;
      enable_q <= '0; // R12
      ack_q <= 1'b0;
    end else begin
      // R1: strobes ignored until init completes; sleep still serviced (R4)
      ack_q <= (bus_wr || bus_rd) && st_q != NSM_INIT && rst_n_int; // R1 R4
      if (bus_rd && st_q != NSM_INIT) begin
        rdata_q <= rdata_d;
        if (bus_addr >= NSM_ADDR_DATA0 && !bus_addr[0])
          ram_hold_q <= ram_q[{1'b0, bus_addr[5:1]}];
      end
      if (bus_wr && st_q != NSM_INIT && rst_n_int) begin // R1
        if (bus_addr == NSM_ADDR_LAMP) lamp_cfg_q <= bus_wdata;
        else if (bus_addr >= NSM_ADDR_ITIME0 && bus_addr <= NSM_ADDR_ITIME2)
          itime_q[8*(bus_addr - NSM_ADDR_ITIME0) +: 8] <= bus_wdata;
        else if (bus_addr >= NSM_ADDR_WTIME0 && bus_addr <= NSM_ADDR_WTIME3)
          wtime_q[8*(bus_addr - NSM_ADDR_WTIME0) +: 8] <= bus_wdata;
        else if (bus_addr == NSM_ADDR_ENABLE) enable_q <= bus_wdata; // R5 R6 R7
        else if (bus_addr >= NSM_ADDR_GAIN0 && bus_addr < NSM_ADDR_GAIN0 + 8'h10)
          gain_q[bus_addr[3:0]] <= (bus_wdata[3:0] > NSM_GAIN_MAX) ?
            NSM_GAIN_MAX : bus_wdata[3:0]; // R15
        else if (bus_addr >= NSM_ADDR_MUX0 && bus_addr < NSM_ADDR_MUX0 + 8'h10)
          mux_q[bus_addr[3:0]] <= bus_wdata[1:0]; // R13 R14
      end
      if (st_q == NSM_STORE) ram_q[ram_idx] <= conv_data[store_idx[3:0]]; // R19
    end
  end

  // converter and lamp outputs
  logic lamps_on;
  assign lamps_on = (st_q == NSM_INTEG || (gate_wait && st_q == NSM_CFG)) &&
    !lamp_phase_q; // R24 R25
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      lamp_en <= '0;
      lamp_high <= 1'b0;
      conv_az <= 1'b0;
      conv_cfg <= 1'b0;
      conv_integ <= 1'b0;
      pass_idx <= '0;
      osc_en <= 1'b0;
      for (int i = 0; i < NSM_NUM_CONV; i++) begin
        conv_gain[i] <= '0;
        conv_pd_sel[i] <= '0;
      end
    end else begin
      lamp_en <= lamps_on ? lamp_cfg_q[3:0] : 4'h0; // R22
      lamp_high <= lamp_cfg_q[NSM_LAMP_HI_BIT]; // R22
      conv_az <= st_q == NSM_AZ; // R16
      conv_cfg <= st_q == NSM_CFG; // R17
      conv_integ <= st_q == NSM_INTEG; // R8
      pass_idx <= pass_q;
      osc_en <= st_q != NSM_SLEEP && st_q != NSM_INIT; // R3 R5
      if (st_q == NSM_CFG) begin
        for (int i = 0; i < NSM_NUM_CONV; i++) begin
          conv_gain[i] <= gain_q[i]; // R8 R17
          conv_pd_sel[i] <= mux_q[i]; // R13
        end
      end
    end
  end

  assign bus_rdata = rdata_q;
  assign bus_ack = ack_q;
  assign gpio_out = gpio_q; // R11
  assign gpio_oe_n = trig_mode; // R11
endmodule : nsm_ctrl

//--- rtl/nsm_pkg.sv
// constants and types shared by the spectral measurement controller
package nsm_pkg;
  localparam logic [7:0] NSM_ADDR_LAMP = 8'h60;
  localparam logic [7:0] NSM_ADDR_ITIME0 = 8'h61;
  localparam logic [7:0] NSM_ADDR_ITIME2 = 8'h63;
  localparam logic [7:0] NSM_ADDR_WTIME0 = 8'h64;
  localparam logic [7:0] NSM_ADDR_WTIME3 = 8'h67;
  localparam logic [7:0] NSM_ADDR_ENABLE = 8'h80;
  localparam logic [7:0] NSM_ADDR_STATUS = 8'h81;
  localparam logic [7:0] NSM_ADDR_GAIN0 = 8'h90;
  localparam logic [7:0] NSM_ADDR_MUX0 = 8'ha0;
  localparam logic [7:0] NSM_ADDR_DATA0 = 8'hc0;
  localparam int NSM_NUM_CONV = 16;
  localparam int NSM_NUM_PASS = 4;
  localparam int NSM_DATA_BYTES = 128;
  localparam int NSM_ENABLE_POWER_BIT = 0;
  localparam int NSM_ENABLE_MEAS_BIT = 1;
  localparam int NSM_ENABLE_INTERPASS_DELAY_BIT = 3;
  localparam int NSM_ENABLE_GPIO_TRIG_BIT = 4;
  localparam int NSM_LAMP_ALT_BIT = 4;
  localparam int NSM_LAMP_WAIT_GATE_BIT = 5;
  localparam int NSM_LAMP_HI_BIT = 6;
  localparam logic [3:0] NSM_GAIN_MAX = 4'h8;
  localparam logic [7:0] NSM_RESET_BYTE = 8'h00;
  localparam int NSM_INIT_US = 10;
  localparam int NSM_CLK_MHZ = 50;
  localparam int NSM_INIT_CYCLES = NSM_INIT_US * NSM_CLK_MHZ;
  localparam int NSM_AZ_CYCLES = 16;
  localparam int NSM_CFG_CYCLES = 16;
  localparam int NSM_STORE_CYCLES = NSM_NUM_CONV;
  typedef enum logic [3:0] {
    NSM_INIT = 4'h0,
    NSM_SLEEP = 4'h1,
    NSM_IDLE = 4'h2,
    NSM_TRIG = 4'h3,
    NSM_AZ = 4'h4,
    NSM_CFG = 4'h5,
    NSM_INTEG = 4'h6,
    NSM_STORE = 4'h7,
    NSM_INTERPASS_DELAY = 4'h8,
    NSM_MOVE = 4'h9,
    NSM_INTERMEASURE_DELAY = 4'ha
  } nsm_state_t;
endpackage : nsm_pkg

//--- rtl/nsm_sync.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module nsm_sync #(
  parameter int W = 1
) (
  input wire logic ref_clk, // clock
  input wire logic rstn, // async reset, active low
  input wire logic [W-1:0] din, // asynchronous input
  output logic [W-1:0] dout // synchronised level
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      s1_q <= '0;
      s2_q <= '0;
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
    end
  end
  assign dout = s2_q;
endmodule : nsm_sync
